// file: hdl/ssx_exec.sv
// Purpose: execution of increment-skip, nonzero-skip, subtract and nibble exchange
// Assumes: sequencer presents the addressed byte and accumulator with op_valid
// Notes: a taken skip holds op_ready low for one dummy instruction cycle
module ssx_exec
    import ssx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [DATA_W-1:0] mem_rd_data,
    input wire logic [DATA_W-1:0] acc_rd_data,
    output logic op_ready,
    output logic op_done,
    output logic acc_wr_en,
    output logic [DATA_W-1:0] acc_wr_data,
    output logic mem_wr_en,
    output logic [DATA_W-1:0] mem_wr_data,
    output logic flags_wr_en,
    output logic [FLAG_W-1:0] flags_wr_data,
    output logic skip_next,
    output logic dummy_cycle
);

    ssx_regs_t regs_reg;
    ssx_regs_t regs_next;

    logic op_take;
    logic [DATA_W-1:0] inc_sum;
    logic [DATA_W-1:0] sub_diff;
    logic [FLAG_W-1:0] sub_flags;
    logic [DATA_W-1:0] swapped;

    ssx_sub_flags #(
        .W(DATA_W)
    ) u_sub (
        .minuend(acc_rd_data),
        .subtrahend(mem_rd_data),
        .difference(sub_diff),
        .flags(sub_flags)
    );

    assign op_ready = (regs_reg.state == ST_IDLE);
    assign op_take = op_valid && op_ready;
    assign inc_sum = mem_rd_data + ONE_BYTE;
    assign swapped = {mem_rd_data[DATA_W/2-1:0], mem_rd_data[DATA_W-1:DATA_W/2]};

    always_comb begin
        regs_next = regs_reg;
        regs_next.acc_wr = 1'b0;
        regs_next.mem_wr = 1'b0;
        regs_next.flags_wr = 1'b0;
        regs_next.skip = 1'b0;
        regs_next.dummy = 1'b0;
        regs_next.done = 1'b0;
        case (regs_reg.state)
            ST_IDLE: begin
                if (op_valid) begin
                    regs_next.done = 1'b1;
                    case (op_code)
                        OP_INC_SKIP_ZERO_TO_ACCUM: begin
                            // memory port stays quiet, only the accumulator takes the sum
                            regs_next.acc_wr = 1'b1;
                            regs_next.acc_data = inc_sum;
                            regs_next.skip = (inc_sum == ZERO_BYTE);
                        end
                        OP_SKIP_IF_NONZERO: begin
                            regs_next.skip = (mem_rd_data != ZERO_BYTE);
                        end
                        OP_SUBTRACT_TO_ACCUM: begin
                            regs_next.acc_wr = 1'b1;
                            regs_next.acc_data = sub_diff;
                            regs_next.flags_wr = 1'b1;
                            regs_next.flags = sub_flags;
                        end
                        OP_SUBTRACT_TO_MEMORY: begin
                            regs_next.mem_wr = 1'b1;
                            regs_next.mem_data = sub_diff;
                            regs_next.flags_wr = 1'b1;
                            regs_next.flags = sub_flags;
                        end
                        OP_NIBBLE_EXCHANGE: begin
                            regs_next.mem_wr = 1'b1;
                            regs_next.mem_data = swapped;
                        end
                        default: begin
                            // unknown code completes with no effect
                            regs_next.done = 1'b1;
                        end
                    endcase
                    if (regs_next.skip) begin
                        // completion moves to the dummy cycle
                        regs_next.done = 1'b0;
                        regs_next.state = ST_DUMMY;
                    end
                end
            end
            ST_DUMMY: begin
                // dummy slot writes nothing so the skipped instruction leaves no trace
                regs_next.dummy = 1'b1;
                regs_next.done = 1'b1;
                regs_next.state = ST_IDLE;
            end
            default: begin
                regs_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regs_reg <= SSX_REGS_RESET;
        end else begin
            regs_reg <= regs_next;
        end
    end

    assign op_done = regs_reg.done;
    assign acc_wr_en = regs_reg.acc_wr;
    assign acc_wr_data = regs_reg.acc_data;
    assign mem_wr_en = regs_reg.mem_wr;
    assign mem_wr_data = regs_reg.mem_data;
    assign flags_wr_en = regs_reg.flags_wr;
    assign flags_wr_data = regs_reg.flags;
    assign skip_next = regs_reg.skip;
    assign dummy_cycle = regs_reg.dummy;

    // helper copies of the taken op for checks
    logic take_inc;
    logic take_nz;
    logic take_sub_acc;
    logic take_sub_mem;
    logic take_swap;
    logic take_sub;
    logic [DATA_W-1:0] exp_diff;
    logic exp_no_borrow;
    logic exp_zero;
    logic [DATA_W:0] exp_sdiff;
    logic exp_wrap;
    logic exp_nib_free;

    assign take_inc = op_take && (op_code == OP_INC_SKIP_ZERO_TO_ACCUM);
    assign take_nz = op_take && (op_code == OP_SKIP_IF_NONZERO);
    assign take_sub_acc = op_take && (op_code == OP_SUBTRACT_TO_ACCUM);
    assign take_sub_mem = op_take && (op_code == OP_SUBTRACT_TO_MEMORY);
    assign take_swap = op_take && (op_code == OP_NIBBLE_EXCHANGE);
    assign take_sub = take_sub_acc || take_sub_mem;
    assign exp_diff = acc_rd_data - mem_rd_data;
    assign exp_no_borrow = (acc_rd_data >= mem_rd_data);
    assign exp_zero = (acc_rd_data == mem_rd_data);
    // sign-extended difference: top two bits differ on signed overflow
    assign exp_sdiff = {acc_rd_data[DATA_W-1], acc_rd_data} - {mem_rd_data[DATA_W-1], mem_rd_data};
    assign exp_wrap = exp_sdiff[DATA_W] ^ exp_sdiff[DATA_W-1];
    assign exp_nib_free = (acc_rd_data[DATA_W/2-1:0] >= mem_rd_data[DATA_W/2-1:0]);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    inc_to_accum_a: assert property (take_inc |=> acc_wr_en && !mem_wr_en
        && acc_wr_data == $past(inc_sum)) else $error("increment result not in accumulator");

    inc_skip_a: assert property (take_inc |=> skip_next == ($past(mem_rd_data) == 8'hFF))
        else $error("increment skip decision wrong");

    skip_dummy_a: assert property (skip_next |-> !op_done && !op_ready
        ##1 (dummy_cycle && op_done && op_ready && !acc_wr_en && !mem_wr_en && !flags_wr_en))
        else $error("skip did not insert one dummy cycle");

    nz_skip_a: assert property (take_nz |=> skip_next == ($past(mem_rd_data) != 8'h00)
        && !acc_wr_en && !mem_wr_en) else $error("nonzero skip decision wrong");

    sub_accum_a: assert property (take_sub_acc |=> acc_wr_en && !mem_wr_en
        && acc_wr_data == $past(exp_diff)) else $error("subtract to accumulator wrong");

    sub_memory_a: assert property (take_sub_mem |=> mem_wr_en && !acc_wr_en
        && mem_wr_data == $past(exp_diff)) else $error("subtract to memory wrong");

    borrow_free_a: assert property (take_sub |=> flags_wr_en
        && flags_wr_data[FLAG_BORROW_FREE] == $past(exp_no_borrow)) else $error("borrow free flag wrong");

    sub_flags_a: assert property (take_sub |=> flags_wr_en && op_done
        && flags_wr_data[FLAG_NULL_RESULT] == $past(exp_zero)
        && flags_wr_data[FLAG_MULTI_BYTE_NULL] == $past(exp_zero)) else $error("zero flags wrong");

    swap_place_a: assert property (take_swap |=> mem_wr_en && !acc_wr_en && !skip_next
        && mem_wr_data == {$past(mem_rd_data[3:0]), $past(mem_rd_data[7:4])}) else $error("nibble exchange wrong");

    swap_flags_a: assert property (take_swap |=> !flags_wr_en) else $error("swap touched flags");

    flags_source_a: assert property (flags_wr_en |-> $past(take_sub))
        else $error("flags written by a non-subtract op");

    done_latency_a: assert property (op_take ##1 !skip_next |-> op_done) else $error("missing completion");

    sub_wrap_a: assert property (take_sub |=> flags_wr_data[FLAG_SIGNED_WRAP] == $past(exp_wrap))
        else $error("signed wrap flag wrong");

    sub_nibble_a: assert property (take_sub |=>
        flags_wr_data[FLAG_NIBBLE_BORROW] == $past(exp_nib_free)) else $error("nibble borrow flag wrong");

    sub_sign_a: assert property (take_sub |=>
        flags_wr_data[FLAG_SIGNED_BORROW] == $past(exp_sdiff[DATA_W])) else $error("signed borrow flag wrong");

    skip_ops_flags_a: assert property ((take_inc || take_nz) |=> !flags_wr_en)
        else $error("skip op touched flags");

    plain_no_skip_a: assert property ((take_sub || take_swap) |=> !skip_next && op_done)
        else $error("non-skip op skipped");

    idle_quiet_a: assert property ((op_ready && !op_valid) |=> !op_done && !acc_wr_en
        && !mem_wr_en && !flags_wr_en && !skip_next) else $error("pulse without an instruction");

    ready_gap_a: assert property (!op_ready |=> op_ready) else $error("ready held low too long");

    skip_taken_c: cover property (take_inc ##1 skip_next ##1 dummy_cycle);
    nz_skip_c: cover property (take_nz ##1 skip_next);
    sub_borrow_c: cover property (take_sub ##1 !flags_wr_data[FLAG_BORROW_FREE]);
    back_to_back_c: cover property (take_swap ##1 take_sub_mem);
    refused_c: cover property (op_valid && !op_ready);

endmodule : ssx_exec

// file: hdl/ssx_pkg.sv
// Purpose: constants and types for the skip / subtract / swap execution block
// Assumes: 8-bit data memory and accumulator, one instruction cycle per clk_sys edge
// Notes: flag vector bit positions are shared by the flag unit and the sequencer
package ssx_pkg;

    localparam int DATA_W = 8;
    localparam int FLAG_W = 6;

    // flag vector bit positions
    localparam int FLAG_SIGNED_WRAP = 0;
    localparam int FLAG_NULL_RESULT = 1;
    localparam int FLAG_NIBBLE_BORROW = 2;
    localparam int FLAG_BORROW_FREE = 3;
    localparam int FLAG_SIGNED_BORROW = 4;
    localparam int FLAG_MULTI_BYTE_NULL = 5;

    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

    typedef enum logic [2:0] {
        OP_INC_SKIP_ZERO_TO_ACCUM = 3'h0,
        OP_SKIP_IF_NONZERO = 3'h1,
        OP_SUBTRACT_TO_ACCUM = 3'h2,
        OP_SUBTRACT_TO_MEMORY = 3'h3,
        OP_NIBBLE_EXCHANGE = 3'h4
    } ssx_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DUMMY = 2'h1
    } ssx_state_t;

    typedef struct packed {
        ssx_state_t state;
        logic acc_wr;
        logic [DATA_W-1:0] acc_data;
        logic mem_wr;
        logic [DATA_W-1:0] mem_data;
        logic flags_wr;
        logic [FLAG_W-1:0] flags;
        logic skip;
        logic dummy;
        logic done;
    } ssx_regs_t;

    localparam ssx_regs_t SSX_REGS_RESET = '0;

endpackage : ssx_pkg

// file: hdl/ssx_sub_flags.sv
// Purpose: accumulator minus memory byte with the six status flags
// Assumes: purely combinational, operands stable within the cycle
// Notes: nibble and byte borrow flags are borrow-free, set means no borrow; signed borrow is set on a borrow
module ssx_sub_flags
    import ssx_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic [W-1:0] minuend,
    input wire logic [W-1:0] subtrahend,
    output logic [W-1:0] difference,
    output logic [FLAG_W-1:0] flags
);

    localparam int H = W / 2;

    logic [W:0] full_diff;
    logic [H:0] low_diff;
    logic wrap;

    assign full_diff = {1'b0, minuend} - {1'b0, subtrahend};
    assign low_diff = {1'b0, minuend[H-1:0]} - {1'b0, subtrahend[H-1:0]};
    assign difference = full_diff[W-1:0];
    // signs differ and result sign follows the subtrahend
    assign wrap = (minuend[W-1] ^ subtrahend[W-1]) & (minuend[W-1] ^ full_diff[W-1]);

    always_comb begin
        flags = '0;
        flags[FLAG_SIGNED_WRAP] = wrap;
        flags[FLAG_NULL_RESULT] = (full_diff[W-1:0] == '0);
        flags[FLAG_NIBBLE_BORROW] = ~low_diff[H];
        flags[FLAG_BORROW_FREE] = ~full_diff[W];
        flags[FLAG_SIGNED_BORROW] = wrap ^ full_diff[W-1];
        // single-byte subtract: chain zero equals plain zero
        flags[FLAG_MULTI_BYTE_NULL] = (full_diff[W-1:0] == '0);
    end

endmodule : ssx_sub_flags

// file: verif/skip_subtract_swap_exec_tb.sv
// Purpose: self-checking bench for the execution block
// Assumes: one instruction at a time, outputs sampled at the falling edge
// Notes: expected results worked out here from plain arithmetic
module skip_subtract_swap_exec_tb
    import ssx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, reset, op_valid, preset;
    logic [2:0] op_code;
    logic [7:0] pacc, pmem, acc, mem, acc_w, mem_w, s1, s2, d, f;
    logic op_ready, op_done, acc_wr_en, mem_wr_en, flags_wr_en, skip_next, dummy_cycle;
    logic [5:0] flags_wr_data;
    logic [7:0] vals [4] = '{8'hFF, 8'h7F, 8'h00, 8'h80};
    int errors = 0, num_checks = 0, cycles = 0;
    // bits: ready, done, acc, mem, flags, skip, dummy
    wire logic [7:0] st = {1'b0, op_ready, op_done, acc_wr_en, mem_wr_en, flags_wr_en, skip_next, dummy_cycle};

    ssx_core_model model (.clk_sys(clk_sys), .preset(preset), .preset_acc(pacc), .preset_mem(pmem),
        .acc_wr_en(acc_wr_en), .acc_wr_data(acc_w), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_w),
        .acc_rd_data(acc), .mem_rd_data(mem));
    ssx_exec uut (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid), .op_code(op_code),
        .mem_rd_data(mem), .acc_rd_data(acc), .op_ready(op_ready), .op_done(op_done),
        .acc_wr_en(acc_wr_en), .acc_wr_data(acc_w), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_w),
        .flags_wr_en(flags_wr_en), .flags_wr_data(flags_wr_data), .skip_next(skip_next),
        .dummy_cycle(dummy_cycle));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // generous ceiling: the whole run is well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            summarize();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // preset core, present op for one take, capture the two answer cycles
    task automatic exec(input logic [2:0] op, input logic [7:0] a, input logic [7:0] m);
        @(posedge clk_sys);
        preset <= 1'b1;
        pacc <= a;
        pmem <= m;
        @(posedge clk_sys);
        preset <= 1'b0;
        op_valid <= 1'b1;
        op_code <= op;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        @(negedge clk_sys);
        s1 = st;
        @(negedge clk_sys);
        s2 = st;
    endtask : exec

    task automatic inc_scen();
        foreach (vals[i]) begin
            exec(3'h0, 8'h33, vals[i]);
            check(s1, vals[i] == 8'hFF ? 8'h12 : 8'h70);
            check(s2, vals[i] == 8'hFF ? 8'h61 : 8'h40);
            check(acc, vals[i] + 8'h01);
            check(mem, vals[i]);
        end
    endtask : inc_scen

    task automatic nz_scen();
        foreach (vals[i]) begin
            exec(3'h1, 8'h44, vals[i]);
            check(s1, vals[i] != 8'h00 ? 8'h02 : 8'h60);
            check(s2, vals[i] != 8'h00 ? 8'h61 : 8'h40);
            check({acc, mem} == {8'h44, vals[i]}, 8'h01);
        end
    endtask : nz_scen

    task automatic sub_scen();
        for (int op = 2; op < 4; op++) begin
            foreach (vals[i]) begin
                foreach (vals[j]) begin
                    exec(op[2:0], vals[i], vals[j]);
                    d = vals[i] - vals[j];
                    f[0] = (vals[i][7] != vals[j][7]) && (d[7] != vals[i][7]);
                    f[1] = d == 8'h00;
                    f[2] = vals[i][3:0] >= vals[j][3:0];
                    f[3] = vals[i] >= vals[j];
                    f[4] = f[0] ^ d[7];
                    f[5] = f[1];
                    check(s1, op == 2 ? 8'h74 : 8'h6C);
                    check(op == 2 ? acc : mem, d);
                    check(op == 2 ? mem : acc, vals[op == 2 ? j : i]);
                    check({7'h00, flags_wr_data[3]}, {7'h00, f[3]});
                    check({2'h0, flags_wr_data}, {2'h0, f[5:0]});
                end
            end
        end
    endtask : sub_scen

    task automatic swap_scen();
        exec(3'h4, 8'h11, 8'hA5);
        check(s1, 8'h68);
        check(mem, 8'h5A);
        check(acc, 8'h11);
    endtask : swap_scen

    // op held through the dummy slot must be taken once, after it
    task automatic refuse_scen();
        @(posedge clk_sys);
        preset <= 1'b1;
        pacc <= 8'h11;
        pmem <= 8'hC3;
        @(posedge clk_sys);
        preset <= 1'b0;
        op_valid <= 1'b1;
        op_code <= 3'h1;
        @(posedge clk_sys);
        op_code <= 3'h4;
        @(negedge clk_sys);
        check(st, 8'h02);
        @(negedge clk_sys);
        check(st, 8'h61);
        @(posedge clk_sys);
        op_valid <= 1'b0;
        @(negedge clk_sys);
        check(st, 8'h68);
        @(negedge clk_sys);
        check(mem, 8'h3C);
        check(acc, 8'h11);
        check(st, 8'h40);
        for (int c = 5; c < 8; c++) begin
            exec(c[2:0], 8'h11, 8'h22);
            check(s1, 8'h60);
        end
    endtask : refuse_scen

    initial begin
        reset = 1'b1;
        op_valid = 1'b0;
        op_code = 3'h0;
        preset = 1'b0;
        pacc = 8'h00;
        pmem = 8'h00;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        check(st, 8'h40);
        inc_scen();
        nz_scen();
        sub_scen();
        swap_scen();
        refuse_scen();
        summarize();
    end
endmodule : skip_subtract_swap_exec_tb

// file: verif/ssx_core_model.sv
// Purpose: data memory byte and accumulator facing the execution block
// Assumes: one addressed byte; bench presets it before each instruction
// Notes: writes land on the edge that ends the write pulse, like the real core
module ssx_core_model
    import ssx_pkg::*;
(
    input wire logic clk_sys,
    input wire logic preset,
    input wire logic [DATA_W-1:0] preset_acc,
    input wire logic [DATA_W-1:0] preset_mem,
    input wire logic acc_wr_en,
    input wire logic [DATA_W-1:0] acc_wr_data,
    input wire logic mem_wr_en,
    input wire logic [DATA_W-1:0] mem_wr_data,
    output logic [DATA_W-1:0] acc_rd_data,
    output logic [DATA_W-1:0] mem_rd_data
);
    timeunit 1ns;
    timeprecision 1ns;

    always_ff @(posedge clk_sys) begin
        if (preset) begin
            acc_rd_data <= preset_acc;
            mem_rd_data <= preset_mem;
        end else begin
            if (acc_wr_en) begin
                acc_rd_data <= acc_wr_data;
            end
            if (mem_wr_en) begin
                mem_rd_data <= mem_wr_data;
            end
        end
    end
endmodule : ssx_core_model
